// ---- smbt_pkg.sv ----
// constants, state codes and carrier types for the target-side management bus front end
// assumes a single 25 MHz ref_clk domain; the bus lines arrive asynchronously
package smbt_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned TIMEOUT_MS      = 25;   // clock low longer than this aborts
	localparam int unsigned TIMEOUT_MAX_MS  = 35;   // abort must be complete by this
	localparam int unsigned SEXT_MS         = 25;   // own cumulative stretch per message
	localparam int unsigned MEXT_MS         = 10;   // host stretch per byte segment
	localparam logic [19:0] TIMEOUT_CYC     = 20'(TIMEOUT_MS * CYC_PER_MS);
	localparam logic [19:0] SEXT_CYC        = 20'(SEXT_MS * CYC_PER_MS);
	localparam logic [7:0]  STRETCH_CYC     = 8'h04;  // hold-off after each taken byte
	localparam logic [7:0]  STRAP_SETTLE    = 8'h20;  // settle time per strap probe phase

	// ************************************************************
	// addressing and commands
	// ************************************************************
	localparam logic [6:0]  ARA_ADDR        = 7'h0C;
	localparam logic [7:0]  CMD_ALERT_MASK  = 8'hD8;
	localparam logic [7:0]  CMD_CLEAR_FAULT = 8'h03;
	localparam logic [6:0]  ADDR_BASE_A     = 7'h40;
	localparam logic [6:0]  ADDR_BASE_B     = 7'h10;
	localparam logic [6:0]  ADDR_BASE_C     = 7'h50;
	localparam logic [4:0]  GROUP_B_IDX     = 5'h08;
	localparam logic [4:0]  GROUP_C_IDX     = 5'h10;
	localparam logic [1:0]  RANK_OPEN       = 2'h0;
	localparam logic [1:0]  RANK_LOW        = 2'h1;
	localparam logic [1:0]  RANK_HIGH       = 2'h2;
	localparam logic [15:0] ALERT_MASK_RST  = 16'h0000;
	localparam logic [3:0]  BIT_ACK         = 4'h8;
	localparam logic [3:0]  BIT_END         = 4'h9;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		BUS_IDLE = 3'h0,
		BUS_ADDR = 3'h1,
		BUS_CMD  = 3'h3,
		BUS_WLO  = 3'h2,
		BUS_WHI  = 3'h6,
		BUS_TX   = 3'h7,
		BUS_IGN  = 3'h5
	} smbt_bus_state_t;

	typedef enum logic [1:0] {
		STRAP_UP   = 2'h0,
		STRAP_DOWN = 2'h1,
		STRAP_DONE = 2'h3
	} smbt_strap_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} smbt_line_t;

endpackage : smbt_pkg

// ---- smbt_sync.sv ----
// two-flop synchroniser for a group of asynchronous levels
// assumes the inputs are slow compared with ref_clk
`timescale 1ns/1ps
module smbt_sync #(
	parameter int unsigned W         = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input  wire logic         ref_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta     <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : smbt_sync

// ---- smbt_target.sv ----
// management bus target: strap address decode, timeouts, stretch limit, alert line
// assumes open-drain pads outside, fault_active from same-clock fault logic
// How it works
// RULE_01 - each select pin read as high, low or open; 27 combinations
// RULE_02 - address is seven bits; eighth bit of address byte is read/write
// RULE_03 - ranked index maps to 40h-47h, 10h-17h, then 50h-5Ah
// RULE_04 - clock held low beyond 25 ms means the transfer timed out
// RULE_05 - after timeout, bus state is reset well before 35 ms
// RULE_06 - own total stretching per message limited to 25 ms
// RULE_07 - exceeding stretch limit releases clock and data and resets interface
// RULE_08 - host keeps its stretching within 10 ms per byte segment
// RULE_09 - alert gated by mask register at D8h and automatic response mask
// RULE_10 - automatic mask set only when this part won the alert response read
// RULE_11 - lowest alerting address wins alert response read by arbitration
// RULE_12 - after winning the alert response read, stop driving alert
// RULE_13 - release by masking every fault active at the winning moment
// RULE_14 - automatic masking never alters fault status
// RULE_15 - masked faults stay silent until clear faults reaches this part
// RULE_16 - host should send clear faults whenever it services an alert
// RULE_17 - alert is open-drain and stays low while any part drives it
// RULE_18 - acknowledge only own address or alert response address
// RULE_19 - straps sampled after reset; address held until next reset
`timescale 1ns/1ps
module smbt_target #(
	parameter logic [19:0] TIMEOUT_CYC = smbt_pkg::TIMEOUT_CYC,
	parameter logic [19:0] SEXT_CYC    = smbt_pkg::SEXT_CYC,
	parameter logic [7:0]  STRETCH_CYC = smbt_pkg::STRETCH_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        addr_sel_pin_lo,
	input  wire logic        addr_sel_pin_mid,
	input  wire logic        addr_sel_pin_hi,
	output logic             strap_pull_up,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe_n,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	output logic             alert_line_n_out,
	output logic             alert_line_n_oe_n,
	input  wire logic [15:0] fault_active,
	output logic             clear_faults_pulse,
	output logic [15:0]      alert_mask,
	output logic [15:0]      auto_response_mask,
	output logic [6:0]       own_addr,
	output logic             addr_valid
);
	smbt_pkg::smbt_line_t        line_s;
	smbt_pkg::smbt_line_t        line_q;
	smbt_pkg::smbt_bus_state_t   state;
	smbt_pkg::smbt_strap_state_t strap_state;
	logic [2:0]  strap_s;
	logic [2:0]  strap_up_cap;
	logic [7:0]  strap_cnt;
	logic [19:0] scl_low_cnt;
	logic [19:0] msg_stretch;
	logic [7:0]  stretch_cnt;
	logic [3:0]  bitcnt;
	logic [7:0]  shreg;
	logic [7:0]  txreg;
	logic [7:0]  cmd_reg;
	logic [7:0]  data_lo;
	logic [15:0] wdata;
	logic        txbit;
	logic        host_ack;
	logic        bytes_left;
	logic        ara_mode;
	logic        mask_wr;
	logic        ara_win;
	logic        stretch_req;
	logic        scl_rise, scl_fall, bus_start, bus_stop;
	logic        tmo_hit, stretch_over, abort, ack_ok, own_hit, ara_hit, alert_on;

	// ************************************************************
	// pin synchronisers and strap decode
	// ************************************************************
	smbt_sync #(.W(2), .RESET_VAL(2'h3)) u_line_sync (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.async_in ({scl_in, sda_in}),
		.sync_out (line_s)
	);

	smbt_sync #(.W(3), .RESET_VAL(3'h0)) u_strap_sync (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.async_in ({addr_sel_pin_hi, addr_sel_pin_mid, addr_sel_pin_lo}),
		.sync_out (strap_s)
	);

	// pin reads same under both pulls: driven; differs: open
	function automatic logic [6:0] smbt_decode(input logic [2:0] up, input logic [2:0] dn);
		logic [4:0] idx;
		logic [1:0] rank;
		idx  = 5'h00;
		rank = smbt_pkg::RANK_OPEN;
		for (int i = 2; i >= 0; i--) begin
			if (up[i] && dn[i])
				rank = smbt_pkg::RANK_HIGH;   // RULE_01
			else if (!up[i] && !dn[i])
				rank = smbt_pkg::RANK_LOW;
			else
				rank = smbt_pkg::RANK_OPEN;
			idx = 5'(idx * 3 + rank);          // RULE_03
		end
		if (idx < smbt_pkg::GROUP_B_IDX)
			return smbt_pkg::ADDR_BASE_A + 7'(idx);
		else if (idx < smbt_pkg::GROUP_C_IDX)
			return smbt_pkg::ADDR_BASE_B + 7'(idx - smbt_pkg::GROUP_B_IDX);
		else
			return smbt_pkg::ADDR_BASE_C + 7'(idx - smbt_pkg::GROUP_C_IDX);
	endfunction : smbt_decode

	// probe with pull-up, then pull-down; decode once and hold
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			strap_state   <= smbt_pkg::STRAP_UP;
			strap_pull_up <= 1'b1;
			strap_cnt     <= 8'h00;
			strap_up_cap  <= 3'h0;
			own_addr      <= 7'h00;
			addr_valid    <= 1'b0;
		end else begin
			case (strap_state)
				smbt_pkg::STRAP_UP: begin
					strap_cnt <= strap_cnt + 8'h01;
					if (strap_cnt == smbt_pkg::STRAP_SETTLE) begin
						strap_up_cap  <= strap_s;
						strap_pull_up <= 1'b0;
						strap_cnt     <= 8'h00;
						strap_state   <= smbt_pkg::STRAP_DOWN;
					end
				end
				smbt_pkg::STRAP_DOWN: begin
					strap_cnt <= strap_cnt + 8'h01;
					if (strap_cnt == smbt_pkg::STRAP_SETTLE) begin
						own_addr    <= smbt_decode(strap_up_cap, strap_s); // RULE_19
						addr_valid  <= 1'b1;
						strap_state <= smbt_pkg::STRAP_DONE;
					end
				end
				smbt_pkg::STRAP_DONE: ;
				default: strap_state <= smbt_pkg::STRAP_UP;
			endcase
		end
	end

	// ************************************************************
	// bus conditions, timeout and stretch limit
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset)
			line_q <= 2'h3;
		else
			line_q <= line_s;
	end

	assign scl_rise  = !line_q.scl && line_s.scl;
	assign scl_fall  = line_q.scl && !line_s.scl;
	assign bus_start = line_q.scl && line_s.scl && line_q.sda && !line_s.sda;
	assign bus_stop  = line_q.scl && line_s.scl && !line_q.sda && line_s.sda;
	assign tmo_hit      = (scl_low_cnt == TIMEOUT_CYC);   // RULE_04
	assign stretch_over = (msg_stretch > SEXT_CYC);       // RULE_06
	assign abort        = tmo_hit || stretch_over;        // RULE_05 RULE_07

	// saturating clock-low counter; abort fires at once, far inside the upper bound
	always_ff @(posedge ref_clk) begin
		if (reset || line_s.scl)
			scl_low_cnt <= 20'h00000;
		else if (!tmo_hit)
			scl_low_cnt <= scl_low_cnt + 20'h00001; // RULE_04
	end

	// own stretch after each taken byte, totalled from first start to stop
	always_ff @(posedge ref_clk) begin
		if (reset || abort) begin
			scl_oe_n    <= 1'b1;                  // RULE_07
			stretch_cnt <= 8'h00;
		end else if (stretch_req) begin
			scl_oe_n    <= 1'b0;
			stretch_cnt <= STRETCH_CYC;
		end else if (stretch_cnt != 8'h00) begin
			stretch_cnt <= stretch_cnt - 8'h01;
			if (stretch_cnt == 8'h01)
				scl_oe_n <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || abort || bus_stop || (bus_start && state == smbt_pkg::BUS_IDLE))
			msg_stretch <= 20'h00000;
		else if (!scl_oe_n)
			msg_stretch <= msg_stretch + 20'h00001; // RULE_06
	end

	// ************************************************************
	// byte engine
	// ************************************************************
	assign alert_on = !alert_line_n_oe_n;
	assign own_hit  = addr_valid && (shreg[7:1] == own_addr) &&
	                  (!shreg[0] || cmd_reg == smbt_pkg::CMD_ALERT_MASK);
	assign ara_hit  = (shreg[7:1] == smbt_pkg::ARA_ADDR) && shreg[0] && alert_on;

	always_comb begin
		case (state)
			smbt_pkg::BUS_ADDR: ack_ok = own_hit || ara_hit; // RULE_18
			smbt_pkg::BUS_CMD:  ack_ok = (shreg == smbt_pkg::CMD_ALERT_MASK) ||
			                             (shreg == smbt_pkg::CMD_CLEAR_FAULT);
			smbt_pkg::BUS_WLO:  ack_ok = 1'b1;
			smbt_pkg::BUS_WHI:  ack_ok = 1'b1;
			default:            ack_ok = 1'b0;
		endcase
	end

	// sampling on clock rise, driving on clock fall; bit 7 first
	always_ff @(posedge ref_clk) begin
		mask_wr            <= 1'b0;
		ara_win            <= 1'b0;
		clear_faults_pulse <= 1'b0;
		stretch_req        <= 1'b0;
		if (reset || abort) begin
			state      <= smbt_pkg::BUS_IDLE;
			sda_oe_n   <= 1'b1;                   // RULE_05 RULE_07
			bitcnt     <= 4'h0;
			shreg      <= 8'h00;
			txreg      <= 8'h00;
			txbit      <= 1'b1;
			host_ack   <= 1'b0;
			bytes_left <= 1'b0;
			ara_mode   <= 1'b0;
			data_lo    <= 8'h00;
			wdata      <= 16'h0000;
			if (reset)
				cmd_reg <= 8'h00;
		end else if (bus_start) begin
			state    <= smbt_pkg::BUS_ADDR;
			bitcnt   <= 4'h0;
			sda_oe_n <= 1'b1;
		end else if (bus_stop) begin
			state    <= smbt_pkg::BUS_IDLE;
			sda_oe_n <= 1'b1;
		end else if (state != smbt_pkg::BUS_IDLE && state != smbt_pkg::BUS_IGN) begin
			if (scl_rise) begin
				bitcnt <= 4'(bitcnt + 4'h1);
				if (bitcnt < smbt_pkg::BIT_ACK) begin
					shreg <= {shreg[6:0], line_s.sda};
					if (state == smbt_pkg::BUS_TX && txbit && !line_s.sda) begin
						state    <= smbt_pkg::BUS_IGN;  // RULE_11
						sda_oe_n <= 1'b1;
					end else if (state == smbt_pkg::BUS_TX && ara_mode && bitcnt == 4'h7)
						ara_win <= 1'b1;                 // RULE_10
				end else
					host_ack <= !line_s.sda;
			end else if (scl_fall) begin
				if (bitcnt == smbt_pkg::BIT_ACK) begin
					if (state == smbt_pkg::BUS_TX)
						sda_oe_n <= 1'b1;
					else if (ack_ok)
						sda_oe_n <= 1'b0;
					else
						state <= smbt_pkg::BUS_IGN;       // RULE_18
				end else if (bitcnt == smbt_pkg::BIT_END) begin
					sda_oe_n    <= 1'b1;
					bitcnt      <= 4'h0;
					stretch_req <= 1'b1;
					case (state)
						smbt_pkg::BUS_ADDR: begin
							if (!shreg[0])
								state <= smbt_pkg::BUS_CMD;
							else if (shreg[7:1] == smbt_pkg::ARA_ADDR) begin
								state      <= smbt_pkg::BUS_TX;
								ara_mode   <= 1'b1;
								bytes_left <= 1'b0;
								sda_oe_n   <= own_addr[6];
								txbit      <= own_addr[6];
								txreg      <= {own_addr[5:0], 2'h2}; // RULE_02
							end else begin
								state      <= smbt_pkg::BUS_TX;
								ara_mode   <= 1'b0;
								bytes_left <= 1'b1;
								sda_oe_n   <= alert_mask[7];
								txbit      <= alert_mask[7];
								txreg      <= {alert_mask[6:0], 1'b0};
							end
						end
						smbt_pkg::BUS_CMD: begin
							cmd_reg <= shreg;
							if (shreg == smbt_pkg::CMD_CLEAR_FAULT) begin
								clear_faults_pulse <= 1'b1;  // RULE_15
								state              <= smbt_pkg::BUS_IGN;
							end else
								state <= smbt_pkg::BUS_WLO;
						end
						smbt_pkg::BUS_WLO: begin
							data_lo <= shreg;
							state   <= smbt_pkg::BUS_WHI;
						end
						smbt_pkg::BUS_WHI: begin
							wdata   <= {shreg, data_lo};
							mask_wr <= 1'b1;
							state   <= smbt_pkg::BUS_IGN;
						end
						smbt_pkg::BUS_TX: begin
							if (host_ack && bytes_left) begin
								bytes_left <= 1'b0;
								sda_oe_n   <= alert_mask[15];
								txbit      <= alert_mask[15];
								txreg      <= {alert_mask[14:8], 1'b0};
							end else
								state <= smbt_pkg::BUS_IGN;
						end
						default: state <= smbt_pkg::BUS_IGN;
					endcase
				end else if (state == smbt_pkg::BUS_TX) begin
					sda_oe_n <= txreg[7];
					txbit    <= txreg[7];
					txreg    <= {txreg[6:0], 1'b0};
				end
			end
		end
	end

	// ************************************************************
	// masks and alert line
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset)
			alert_mask <= smbt_pkg::ALERT_MASK_RST;
		else if (mask_wr)
			alert_mask <= wdata;                      // RULE_09
	end

	// a win in the clear cycle still masks: set beats clear; status is untouched
	always_ff @(posedge ref_clk) begin
		if (reset)
			auto_response_mask <= 16'h0000;
		else
			auto_response_mask <= (clear_faults_pulse ? 16'h0000 : auto_response_mask) |
			                      (ara_win ? fault_active : 16'h0000); // RULE_12 RULE_13 RULE_14
	end

	// open drain: only the enable moves, the driven level is always low
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			alert_line_n_out  <= 1'b0;
			alert_line_n_oe_n <= 1'b1;
			scl_out           <= 1'b0;
			sda_out           <= 1'b0;
		end else begin
			alert_line_n_oe_n <= !(|(fault_active & ~alert_mask & ~auto_response_mask)); // RULE_09 RULE_17
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_win_then_steady;
		ara_win ##1 ($stable(fault_active) && !mask_wr);
	endsequence

	a_alert_gate: assert property (##1 alert_line_n_oe_n == !(|($past(fault_active) & ~$past(alert_mask) & ~$past(auto_response_mask)))) else $error("alert enable disagrees with masks"); // RULE_09
	a_auto_set_cause: assert property (|(auto_response_mask & ~$past(auto_response_mask)) |-> $past(ara_win)) else $error("auto mask set without a won response read"); // RULE_10
	a_auto_clear_cause: assert property (|($past(auto_response_mask) & ~auto_response_mask) |-> $past(clear_faults_pulse)) else $error("auto mask cleared without clear faults"); // RULE_15
	a_ara_release: assert property (s_win_then_steady |-> ##1 alert_line_n_oe_n) else $error("alert still driven after won response read"); // RULE_12
	a_addr_hold: assert property (addr_valid && $past(addr_valid) |-> $stable(own_addr)) else $error("strap address changed"); // RULE_19
	a_addr_range: assert property (addr_valid |-> (own_addr inside {[7'h40:7'h47], [7'h10:7'h17], [7'h50:7'h5A]})) else $error("decoded address out of map"); // RULE_03
	a_timeout_abort: assert property (tmo_hit |=> state == smbt_pkg::BUS_IDLE && sda_oe_n && scl_oe_n) else $error("timeout did not reset bus"); // RULE_04
	a_stretch_abort: assert property (stretch_over |=> sda_oe_n && scl_oe_n && state == smbt_pkg::BUS_IDLE) else $error("stretch limit not enforced"); // RULE_07
	a_foreign_nack: assert property (state == smbt_pkg::BUS_ADDR && scl_fall && bitcnt == smbt_pkg::BIT_ACK && !own_hit && !ara_hit && !bus_start && !bus_stop && !abort |=> sda_oe_n && state == smbt_pkg::BUS_IGN) else $error("foreign address acknowledged"); // RULE_18
	a_stretch_bound: assert property ($fell(scl_oe_n) |-> ##[1:255] scl_oe_n) else $error("stretch not released"); // RULE_06
endmodule : smbt_target

// ---- smbt_host.sv ----
// host-side model of the management bus: drives clock and data open-drain
// assumes the bench resolves both wired-AND lines and feeds them back here
`timescale 1ns/1ps
module smbt_host (
	input  wire logic ref_clk,
	input  wire logic scl_w,
	input  wire logic sda_w,
	output logic      scl_rel,
	output logic      sda_rel,
	output logic      stuck
);
	// ************************************************************
	// line control
	// ************************************************************
	// idle bus: both lines released
	initial begin
		scl_rel = 1'b1;
		sda_rel = 1'b1;
		stuck   = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	// release the clock, then wait out any target stretch under a bound
	task automatic rise();
		int n;
		scl_rel <= 1'b1;
		n = 0;
		while (scl_w !== 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 1000) stuck <= 1'b1;
	endtask : rise

	// data moves only while the clock is low, so no false start or stop
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		sda_rel <= b;
		tick(3);
		rise();
		tick(3);         // four cycles low, four high: 320 ns per bit
		r = sda_w;
		scl_rel <= 1'b0;
	endtask : bit_io

	// works from idle and as a repeated start after a byte
	task automatic start();
		tick(1);
		sda_rel <= 1'b1;
		tick(2);
		rise();
		tick(3);
		sda_rel <= 1'b0;
		tick(3);
		scl_rel <= 1'b0;
		tick(1);
	endtask : start

	task automatic stop();
		tick(1);
		sda_rel <= 1'b0;
		tick(2);
		rise();
		tick(3);
		sda_rel <= 1'b1;
		tick(4);
	endtask : stop

	// clock held low after the ninth bit so a target stretch never glitches
	task automatic tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
		tick(6);
	endtask : tx

	// rival bits model a lower-addressed part pulling data low
	task automatic rx(input logic [7:0] rival, input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(rival[i], d[i]);
		bit_io(nack, r);
		tick(6);
	endtask : rx

endmodule : smbt_host

// ---- smbt_target_tb.sv ----
// self-checking bench for the management bus target front end
// assumes smbt_host as bus partner; weak strap pulls are modelled here
`timescale 1ns/1ps
module smbt_target_tb;
	localparam int TO_CYC = 2000;  // shortened clock-low timeout
	logic        ref_clk, reset, a, strap_pull_up, scl_oe_n, sda_oe_n;
	logic        alert_line_n_oe_n, clear_faults_pulse, addr_valid;
	logic        scl_rel, sda_rel, stuck;
	logic        scl_o, sda_o, alert_o;
	logic [1:0]  rank [3];         // per strap pin: 0 open, 1 low, 2 high
	logic [15:0] fault_active, alert_mask, auto_response_mask, v;
	logic [6:0]  own_addr, oa;
	int          err_count, checks, pulses;
	wire         scl_w, sda_w, alert_w, pin_lo, pin_mid, pin_hi;

	// ************************************************************
	// wiring
	// ************************************************************
	// wired-AND lines with pull-ups; open straps follow the probe pull
	assign scl_w   = scl_rel & (scl_oe_n | scl_o);
	assign sda_w   = sda_rel & (sda_oe_n | sda_o);
	assign alert_w = alert_line_n_oe_n | alert_o;
	assign pin_lo  = (rank[0] == smbt_pkg::RANK_OPEN) ? strap_pull_up : rank[0][1];
	assign pin_mid = (rank[1] == smbt_pkg::RANK_OPEN) ? strap_pull_up : rank[1][1];
	assign pin_hi  = (rank[2] == smbt_pkg::RANK_OPEN) ? strap_pull_up : rank[2][1];

	smbt_target #(.TIMEOUT_CYC(20'h007D0), .SEXT_CYC(20'h00028), .STRETCH_CYC(8'h04)) i_smbt_target (
		.ref_clk(ref_clk), .reset(reset), .addr_sel_pin_lo(pin_lo),
		.addr_sel_pin_mid(pin_mid), .addr_sel_pin_hi(pin_hi), .strap_pull_up(strap_pull_up),
		.scl_in(scl_w), .scl_out(scl_o), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_o),
		.sda_oe_n(sda_oe_n), .alert_line_n_out(alert_o), .alert_line_n_oe_n(alert_line_n_oe_n),
		.fault_active(fault_active), .clear_faults_pulse(clear_faults_pulse),
		.alert_mask(alert_mask), .auto_response_mask(auto_response_mask),
		.own_addr(own_addr), .addr_valid(addr_valid));

	smbt_host i_smbt_host (.ref_clk(ref_clk), .scl_w(scl_w), .sda_w(sda_w),
		.scl_rel(scl_rel), .sda_rel(sda_rel), .stuck(stuck));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// a stuck bus wait or a clear-faults strobe, watched every cycle
	always @(posedge ref_clk) begin
		if (clear_faults_pulse === 1'b1) pulses++;
		if (stuck === 1'b1) begin
			err_count++;
			test_done();
		end
	end

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	task automatic do_reset();
		@(posedge ref_clk);
		reset <= 1'b1;
		tick(3);
		reset <= 1'b0;
	endtask : do_reset

	task automatic wait_valid();
		int n;
		for (n = 0; n < 300 && addr_valid !== 1'b1; n++) @(posedge ref_clk);
		if (n == 300) begin
			err_count++;
			test_done();
		end
	endtask : wait_valid

	// first eight from 40h, next eight from 10h, last eleven from 50h
	function automatic logic [15:0] exp_addr(input int i);
		if (i < 8) return 16'h0040 + 16'(i);
		if (i < 16) return 16'h0010 + 16'(i - 8);
		return 16'h0050 + 16'(i - 16);
	endfunction : exp_addr

	task automatic put(input logic [7:0] b, input logic ea);
		i_smbt_host.tx(b, a);
		chk("ack", {15'h0000, ea}, {15'h0000, a});
	endtask : put

	task automatic wr_mask(input logic [15:0] m);
		i_smbt_host.start();
		put({oa, 1'b0}, 1'b1);
		put(8'hD8, 1'b1);
		put(m[7:0], 1'b1);
		put(m[15:8], 1'b1);
		i_smbt_host.stop();
		tick(3);
	endtask : wr_mask

	task automatic rd_mask(output logic [15:0] m);
		i_smbt_host.start();
		put({oa, 1'b0}, 1'b1);
		put(8'hD8, 1'b1);
		i_smbt_host.start();
		put({oa, 1'b1}, 1'b1);
		i_smbt_host.rx(8'hFF, 1'b0, m[7:0]);
		i_smbt_host.rx(8'hFF, 1'b1, m[15:8]);
		i_smbt_host.stop();
	endtask : rd_mask

	task automatic ara(input logic [7:0] rival, output logic [7:0] d);
		i_smbt_host.start();
		put(8'h19, 1'b1);
		i_smbt_host.rx(rival, 1'b1, d);
		i_smbt_host.stop();
		tick(3);
	endtask : ara

	task automatic clr(input logic [6:0] ad, input logic ea);
		i_smbt_host.start();
		put({ad, 1'b0}, ea);
		if (ea) put(8'h03, 1'b1);
		i_smbt_host.stop();
		tick(3);
	endtask : clr

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		reset = 1'b1;
		fault_active = 16'h0000;
		rank[0] = 2'h0;
		rank[1] = 2'h0;
		rank[2] = 2'h0;
		err_count = 0;
		checks = 0;
		pulses = 0;
		oa = 7'h15;
		v = 16'h0000;
		for (int i = 0; i < 27; i++) begin
			rank[2] <= 2'(i / 9);
			rank[1] <= 2'((i / 3) % 3);
			rank[0] <= 2'(i % 3);
			do_reset();
			wait_valid();
			chk("own_addr", exp_addr(i), {9'h000, own_addr});
		end
		rank[0] <= 2'h1;
		rank[1] <= 2'h1;
		rank[2] <= 2'h1;
		do_reset();
		wait_valid();
		chk("alert_mask", 16'h0000, alert_mask);
		rank[0] <= 2'h2;
		tick(100);
		chk("own_addr", 16'h0015, {9'h000, own_addr});
		rank[0] <= 2'h1;
		$display("test strap decode done");
		fault_active <= 16'h0005;
		tick(3);
		chk("alert", 16'h0000, {15'h0000, alert_w});
		wr_mask(16'h0005);
		chk("alert", 16'h0001, {15'h0000, alert_w});
		rd_mask(v);
		chk("mask read", 16'h0005, v);
		wr_mask(16'h0000);
		chk("alert", 16'h0000, {15'h0000, alert_w});
		$display("test mask register done");
		ara(8'h0B, v[7:0]);
		chk("ara lost", 16'h000B, {8'h00, v[7:0]});
		chk("auto mask", 16'h0000, auto_response_mask);
		chk("alert", 16'h0000, {15'h0000, alert_w});
		ara(8'hFF, v[7:0]);
		chk("ara won", 16'h002B, {8'h00, v[7:0]});
		chk("auto mask", 16'h0005, auto_response_mask);
		chk("alert", 16'h0001, {15'h0000, alert_w});
		fault_active <= 16'h0105;
		tick(3);
		chk("alert", 16'h0000, {15'h0000, alert_w});
		ara(8'hFF, v[7:0]);
		fault_active <= 16'h0005;
		tick(3);
		chk("alert", 16'h0001, {15'h0000, alert_w});
		clr(7'h14, 1'b0);
		chk("auto mask", 16'h0105, auto_response_mask);
		i_smbt_host.start();
		put({oa, 1'b0}, 1'b1);
		put(8'h99, 1'b0);
		i_smbt_host.stop();
		clr(oa, 1'b1);
		chk("auto mask", 16'h0000, auto_response_mask);
		chk("alert", 16'h0000, {15'h0000, alert_w});
		chk("clear pulses", 16'h0001, 16'(pulses));
		$display("test alert response done");
		i_smbt_host.start();
		put({oa, 1'b0}, 1'b1);
		put(8'hD8, 1'b1);
		put(8'h34, 1'b1);
		tick(TO_CYC + 20);
		chk("scl_oe_n", 16'h0001, {15'h0000, scl_oe_n});
		put(8'h12, 1'b0);
		i_smbt_host.stop();
		rd_mask(v);
		chk("mask read", 16'h0000, v);
		$display("test clock timeout done");
		// eleven stretched bytes in one message pass the shortened stretch limit
		for (int i = 0; i < 11; i++) begin
			i_smbt_host.start();
			put({oa, 1'b0}, 1'b1);
		end
		put(8'hD8, 1'b0);
		i_smbt_host.stop();
		$display("test stretch limit done");
		test_done();
	end

endmodule : smbt_target_tb
